// ### pkg/scs_pkg.sv
package scs_pkg;

    // ------------------------------------------------------------
    // Conversion geometry and timing
    // ------------------------------------------------------------
    localparam int          SCS_NBITS        = 16;
    localparam int          SCS_IDX_W        = 4;
    localparam int          SCS_CLK_NS       = 50;
    localparam int          SCS_RATE_KSPS    = 500;
    localparam int          SCS_PERIOD_NS    = 1_000_000 / SCS_RATE_KSPS;
    // Whole cycles per sample slot (longest time, rounded down)
    localparam int          SCS_PERIOD_CYC   = SCS_PERIOD_NS / SCS_CLK_NS;
    // Cycles per trial: apply weight, then judge comparator
    localparam int          SCS_TRIAL_CYC    = 2;
    // Open, ground, trials, finish
    localparam int          SCS_CONV_CYC     = 3 + SCS_NBITS * SCS_TRIAL_CYC;
    localparam int          SCS_ACQ_MIN_CYC  = SCS_PERIOD_CYC - SCS_CONV_CYC;

    // ------------------------------------------------------------
    // Code values and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] SCS_SIGN_FLIP    = 16'h8000;
    localparam logic [15:0] SCS_MSB_TRIAL    = 16'h8000;
    localparam logic [15:0] SCS_CODE_POS_MAX = 16'h7FFF;
    localparam logic [15:0] SCS_CODE_NEG_MAX = 16'h8000;
    localparam logic [15:0] SCS_CODE_RST     = 16'h0000;
    localparam logic [3:0]  SCS_IDX_MSB      = 4'hF;
    localparam logic [5:0]  SCS_ACQ_CNT_RST  = 6'h00;

    // Sequencer states
    typedef enum logic [2:0] {
        SCS_ACQ      = 3'b000,
        SCS_OPEN_GND = 3'b001,
        SCS_HOLD     = 3'b010,
        SCS_TRIAL    = 3'b011,
        SCS_FINISH   = 3'b100
    } scs_state_t;

    // Switch controls toward the capacitor arrays
    typedef struct packed {
        logic ground_switch_pos;
        logic ground_switch_neg;
        logic array_to_input;
        logic array_to_ground;
        logic analog_on;
    } scs_switch_t;

    // Result toward the serial side
    typedef struct packed {
        logic [15:0] code;
        logic        done;
        logic        busy;
    } scs_result_t;

endpackage : scs_pkg

// ### verilog/scs_trial_reg.sv
`timescale 1ns/1ns

module scs_trial_reg
#(
    parameter int W = 16
)
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // Trial control
    input  wire logic                 load,
    input  wire logic                 decide,
    input  wire logic                 comp_high,
    input  wire logic [$clog2(W)-1:0] bit_idx,
    // Trial word driving the array elements
    output logic      [W-1:0]         word_q
);

    wire [W-1:0] word_d;

    // ------------------------------------------------------------
    // Per-bit next value
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            localparam logic [$clog2(W)-1:0] IDX = ($clog2(W))'(i);
            // Load sets only the top weight
            if (i == W - 1)
            begin : g_top
                assign word_d[i] = load ? 1'b1 :
                                   (decide && bit_idx == IDX) ? comp_high : word_q[i];
            end
            else
            begin : g_low
                // Keep or clear judged bit, raise the next lower weight
                assign word_d[i] = load ? 1'b0 :
                                   (decide && bit_idx == IDX) ? comp_high :
                                   (decide && bit_idx == IDX + 1'b1) ? 1'b1 : word_q[i];
            end
        end
    endgenerate

    // Register the trial word
    always_ff @(posedge clk)
    begin
        if (reset)
            word_q <= '0;
        else
            word_q <= word_d;
    end

endmodule : scs_trial_reg

// ### verilog/scs_sequencer.sv
`timescale 1ns/1ns

module scs_sequencer
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                reset,
    // Near side
    input  wire logic                convert_strobe,
    output scs_pkg::scs_result_t     result_q,
    // Far side: comparator and arrays
    input  wire logic                comp_high,
    output scs_pkg::scs_switch_t     switch_q,
    output logic [15:0]              dac_bits_q
);
    import scs_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    scs_state_t       state_q;
    scs_state_t       state_d;
    logic [3:0]       bit_q;
    logic [3:0]       bit_d;
    logic             phase_q;
    logic             phase_d;
    logic [5:0]       acq_cnt_q;
    logic [5:0]       acq_cnt_d;
    logic             strobe_prev_q;
    scs_switch_t      switch_d;
    scs_result_t      result_d;
    logic             strobe_rise;
    logic             acq_ok;
    logic             start;
    logic             decide;
    logic             load;

    // Accept and judge conditions
    assign strobe_rise = convert_strobe && !strobe_prev_q;
    assign acq_ok      = acq_cnt_q >= 6'(SCS_ACQ_MIN_CYC - 1);
    assign start       = state_q == SCS_ACQ && strobe_rise && acq_ok;
    assign decide      = state_q == SCS_TRIAL && phase_q == 1'(SCS_TRIAL_CYC - 1);
    assign load        = state_q == SCS_HOLD;

    // ------------------------------------------------------------
    // Trial word
    // ------------------------------------------------------------
    // keep or clear
    scs_trial_reg #(.W(SCS_NBITS)) u_trial
    (
        .clk       (clk),
        .reset     (reset),
        .load      (load),
        .decide    (decide),
        .comp_high (comp_high),
        .bit_idx   (bit_q),
        .word_q    (dac_bits_q)
    );

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_d   = state_q;
        bit_d     = bit_q;
        phase_d   = 1'b0;
        acq_cnt_d = acq_cnt_q;
        case (state_q)
            SCS_ACQ:
            begin
                if (acq_cnt_q != 6'h3F)
                    acq_cnt_d = acq_cnt_q + 6'h01;
                if (start)
                    state_d = SCS_OPEN_GND;
            end
            SCS_OPEN_GND:
                state_d = SCS_HOLD;
            SCS_HOLD:
            begin
                state_d = SCS_TRIAL;
                bit_d   = SCS_IDX_MSB;
            end
            SCS_TRIAL:
            begin
                phase_d = !decide;
                if (decide)
                begin
                    if (bit_q == 4'h0)
                        state_d = SCS_FINISH;
                    else
                        bit_d = bit_q - 4'h1;
                end
            end
            SCS_FINISH:
            begin
                state_d   = SCS_ACQ;
                acq_cnt_d = SCS_ACQ_CNT_RST;
            end
            default:
                state_d = SCS_ACQ;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q       <= SCS_ACQ;
            bit_q         <= SCS_IDX_MSB;
            phase_q       <= 1'b0;
            acq_cnt_q     <= SCS_ACQ_CNT_RST;
            strobe_prev_q <= 1'b0;
        end
        else
        begin
            state_q       <= state_d;
            bit_q         <= bit_d;
            phase_q       <= phase_d;
            acq_cnt_q     <= acq_cnt_d;
            strobe_prev_q <= convert_strobe;
        end
    end

    // ------------------------------------------------------------
    // Switch and result outputs
    // ------------------------------------------------------------
    always_comb
    begin
        switch_d.ground_switch_pos = state_d == SCS_ACQ;
        switch_d.ground_switch_neg = state_d == SCS_ACQ;
        switch_d.array_to_input    = state_d == SCS_ACQ || state_d == SCS_OPEN_GND;
        switch_d.array_to_ground   = state_d == SCS_HOLD || state_d == SCS_TRIAL
                                     || state_d == SCS_FINISH;
        switch_d.analog_on         = state_d != SCS_ACQ;
        result_d                   = result_q;
        result_d.done              = 1'b0;
        result_d.busy              = state_d != SCS_ACQ;
        if (state_q == SCS_FINISH)
        begin
            result_d.code = dac_bits_q ^ SCS_SIGN_FLIP;
            result_d.done = 1'b1;
        end
    end

    // Output registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            switch_q <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
            result_q <= '{SCS_CODE_RST, 1'b0, 1'b0};
        end
        else
        begin
            switch_q <= switch_d;
            result_q <= result_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    start_on_rise_a: assert property (start |=> state_q == SCS_OPEN_GND)
        else $error("accepted strobe rise did not start conversion");

    acq_switches_a: assert property (state_q == SCS_ACQ |->
        switch_q.ground_switch_pos && switch_q.ground_switch_neg
        && switch_q.array_to_input && !switch_q.array_to_ground)
        else $error("switches wrong during acquisition");

    break_order_a: assert property ($fell(switch_q.ground_switch_pos) |->
        switch_q.array_to_input && !switch_q.ground_switch_neg
        ##1 !switch_q.array_to_input && switch_q.array_to_ground)
        else $error("arrays left inputs before ground switches opened");

    msb_first_a: assert property (load |=> dac_bits_q == SCS_MSB_TRIAL)
        else $error("first trial is not the top weight");

    trial_decide_a: assert property (decide && bit_q != 4'h0 |=>
        dac_bits_q[$past(bit_q)] == $past(comp_high)
        && dac_bits_q[$past(bit_q) - 4'h1])
        else $error("trial bit not kept per comparator");

    conv_length_a: assert property (start |-> ##36 result_q.done)
        else $error("conversion did not finish in 36 cycles");

    busy_span_a: assert property (start |=> result_q.busy [*8])
        else $error("busy dropped early in conversion");

    result_code_a: assert property (result_q.done |->
        result_q.code == ($past(dac_bits_q) ^ SCS_SIGN_FLIP))
        else $error("result not two's complement of trial word");

    end_state_a: assert property (result_q.done |->
        state_q == SCS_ACQ && switch_q.array_to_input && !result_q.busy)
        else $error("not back in acquisition at completion");

    power_down_a: assert property (state_q == SCS_ACQ |-> !switch_q.analog_on)
        else $error("analog powered during acquisition");

    code_hold_a: assert property (!result_q.done |-> $stable(result_q.code))
        else $error("result changed outside completion");

    start_c: cover property (start);
    pos_full_c: cover property (result_q.done && result_q.code == SCS_CODE_POS_MAX);
    neg_full_c: cover property (result_q.done && result_q.code == SCS_CODE_NEG_MAX);
    strobe_busy_c: cover property (result_q.busy && strobe_rise);

endmodule : scs_sequencer

// ### tb/scs_analog_model.sv
`timescale 1ns/1ns

module scs_analog_model
(
    // Clock
    input  wire logic               clk,
    // Stimulus in steps of one code, and array controls
    input  wire logic signed [17:0] analog_diff,
    input  scs_pkg::scs_switch_t    switch_q,
    input  wire logic [15:0]        dac_bits_q,
    // Comparator decision
    output logic                    comp_high
);
    import scs_pkg::*;

    logic signed [18:0] held_q;
    logic               noise_q = 1'b0;

    // --------------------------------------------------------
    // Sampling arrays
    // --------------------------------------------------------
    // arrays follow input
    always_ff @(posedge clk)
    begin
        if (switch_q.array_to_input)
            held_q <= analog_diff + 19'sh0_8000;
        noise_q <= ~noise_q;
    end

    // decide when floating
    // Powered down or grounded arrays give a meaningless toggling answer
    assign comp_high = (switch_q.analog_on && !switch_q.ground_switch_pos)
                     ? (held_q >= $signed({3'h0, dac_bits_q})) : noise_q;
endmodule : scs_analog_model

// ### tb/test_sar_conversion_sequencer.sv
`timescale 1ns/1ns

module test_sar_conversion_sequencer;
    import scs_pkg::*;

    typedef struct packed {
        logic signed [17:0] vin;
        logic [15:0]        code;
        logic               early;
    } scs_row_t;

    localparam scs_row_t ROWS [10] = '{
        '{18'h0_0000, 16'h0000, 1'b0}, '{18'h0_0001, 16'h0001, 1'b1},
        '{18'h3_FFFF, 16'hFFFF, 1'b0}, '{18'h0_7FFF, 16'h7FFF, 1'b0},
        '{18'h0_9C40, 16'h7FFF, 1'b1}, '{18'h3_8001, 16'h8001, 1'b0},
        '{18'h3_8000, 16'h8000, 1'b0}, '{18'h3_63C0, 16'h8000, 1'b0},
        '{18'h0_3039, 16'h3039, 1'b0}, '{18'h3_CFC7, 16'hCFC7, 1'b0}};

    logic               clk;
    logic               reset;
    logic               convert_strobe;
    logic               comp_high;
    logic signed [17:0] analog_diff;
    scs_result_t        result_q;
    scs_switch_t        switch_q;
    logic [15:0]        dac_bits_q;
    int                 n_fail;
    int                 check_count;

    scs_sequencer i_scs_sequencer (.clk(clk), .reset(reset),
        .convert_strobe(convert_strobe), .result_q(result_q),
        .comp_high(comp_high), .switch_q(switch_q), .dac_bits_q(dac_bits_q));

    scs_analog_model i_scs_analog_model (.clk(clk), .analog_diff(analog_diff),
        .switch_q(switch_q), .dac_bits_q(dac_bits_q), .comp_high(comp_high));

    // Clock, 50 ns period
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    task automatic step();
        @(posedge clk);
        #5;
    endtask : step

    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check16

    task automatic check1(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : check1

    task automatic check_rest();
        check16("idle switches", 16'h001C, {11'h000, switch_q});
        check16("reset code", 16'h0000, result_q.code);
        check16("reset word", 16'h0000, dac_bits_q);
        check1("reset busy", 1'b0, result_q.busy);
        check1("reset done", 1'b0, result_q.done);
    endtask : check_rest

    task automatic end_of_test();
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    // One conversion; strobe is toggled mid-run and may rise early after it
    task automatic convert(input scs_row_t row);
        int done_at;
        done_at = 0;
        convert_strobe = 1'b0;
        analog_diff = row.vin;
        repeat (6)
        begin
            step();
            check1("idle busy", 1'b0, result_q.busy);
        end
        convert_strobe = 1'b1;
        // Index k looks just after edge k; the taking edge is k = 0
        for (int k = 0; k <= 40; k++)
        begin
            step();
            if (k == 0)
                check16("open switches", 16'h0005, {11'h000, switch_q});
            if (k == 1)
                check16("hold switches", 16'h0003, {11'h000, switch_q});
            if (k == 2)
                check16("first trial", 16'h8000, dac_bits_q);
            if (k == 1 || k == 30 && row.early)
                convert_strobe = 1'b0;
            if (k == 9 || k == 37 && row.early)
                convert_strobe = 1'b1;
            if (k == 3)
                analog_diff = ~row.vin;
            if (k <= 34)
            begin
                check1("busy", 1'b1, result_q.busy);
                check1("powered", 1'b1, switch_q.analog_on);
            end
            if (result_q.done === 1'b1 && done_at == 0)
                done_at = k;
            if (k == 35)
            begin
                check1("done", 1'b1, result_q.done);
                check16("code", row.code, result_q.code);
                check16("after switches", 16'h001C, {11'h000, switch_q});
            end
            if (k > 35)
            begin
                check1("done pulse", 1'b0, result_q.done);
                check1("no restart", 1'b0, result_q.busy);
            end
        end
        // Done samples high at edge 36, seen just after edge 35
        check16("done cycle", 16'h0023, done_at[15:0]);
        if (done_at == 0)
            end_of_test();
    endtask : convert

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial
    begin
        n_fail = 0;
        check_count = 0;
        reset = 1'b1;
        convert_strobe = 1'b0;
        analog_diff = 18'h0_0000;
        repeat (8) step();
        check_rest();
        reset = 1'b0;
        step();
        check_rest();
        foreach (ROWS[i])
            convert(ROWS[i]);
        // Reset in the middle of a conversion
        convert_strobe = 1'b0;
        repeat (6) step();
        convert_strobe = 1'b1;
        repeat (10) step();
        reset = 1'b1;
        repeat (2) step();
        reset = 1'b0;
        step();
        check_rest();
        convert(ROWS[8]);
        end_of_test();
    end
endmodule : test_sar_conversion_sequencer
